// file: dv/pin_load.sv
// partner model: pad and external load on one waveform pin
// assumes pin value and enable arrive registered on the timer clock
module pin_load (
  // clock
  input wire logic clk_in,
  // drive from the timer
  input wire logic pin_in,
  input wire logic oe_in,
  // level seen on the pad
  output logic pad_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // pad level
  logic last_r = 1'h0;
  // no pull on this pad: an undriven pad shows the inverse of the last
  // driven level, so stale data never passes for a waveform
  always_ff @(posedge clk_in) begin
    if (oe_in) begin
      last_r <= pin_in;
    end
  end
  assign pad_out = oe_in ? pin_in : ~last_r;
endmodule : pin_load

// file: dv/timer_compare_waveform_modes_tb.sv
// self-checking bench for the compare/waveform timer
// assumes the timer tick is a one-cycle pulse, driven with a gap cycle
module timer_compare_waveform_modes_tb;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    n_fail++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
  // ==========================================================
  // stimulus and observed signals
  logic clk_in, rst_n_in = 1'h0, ce_in = 1'h1, tick_in = 1'h0;
  tcmp_pkg::timer_ctrl_s ctrl_in = '0;
  logic force_a = 1'h0, force_b = 1'h0, count_wr = 1'h0;
  logic cmp_a_wr = 1'h0, cmp_b_wr = 1'h0;
  logic clr_a = 1'h0, clr_b = 1'h0, clr_w = 1'h0;
  logic [7:0] count_data = 8'h00, cmp_data = 8'h00;
  tcmp_pkg::port_pin_s pin_a = '0, pin_b = '0;
  logic [7:0] count_value_out, compare_value_a_out;
  logic ma, mb, wrap, wa, wb, pa, pb, oea, oeb, pad_a;
  int n_fail = 0, checks = 0;
  // one row: setup, tick count, expected count and {ma,mb,wrap,wa,wb}
  typedef struct {
    logic [2:0] mode;
    logic [1:0] sa, sb;
    logic [7:0] ca, cb, c0;
    int n;
    logic [7:0] cnt;
    logic [4:0] fl;
  } row_s;
  row_s rows [10] = '{
    '{3'h0,2'h1,2'h0,8'h10,8'h00,8'hfd,3,8'h00,5'h04}, // normal wrap
    '{3'h0,2'h1,2'h3,8'h05,8'h06,8'h04,3,8'h07,5'h1b}, // toggle, set
    '{3'h0,2'h0,2'h2,8'h05,8'h05,8'h04,2,8'h06,5'h18}, // action none
    '{3'h2,2'h1,2'h0,8'h02,8'h01,8'h00,4,8'h01,5'h1a}, // clear on match
    '{3'h2,2'h1,2'h0,8'h02,8'h00,8'hfe,4,8'h02,5'h0c}, // top missed
    '{3'h3,2'h2,2'h3,8'h02,8'h02,8'hfe,5,8'h03,5'h1d}, // fast pwm
    '{3'h7,2'h1,2'h1,8'h01,8'h00,8'h00,3,8'h01,5'h1e}, // toggle at top
    '{3'h3,2'h1,2'h1,8'h01,8'h01,8'h00,3,8'h03,5'h18}, // reserved codes
    '{3'h3,2'h3,2'h0,8'hff,8'h80,8'hfd,4,8'h01,5'h16}, // compare at max
    '{3'h3,2'h2,2'h0,8'h00,8'h80,8'hfe,2,8'h00,5'h06}  // compare at zero
  };
  // ==========================================================
  // design and pad model
  timer_compare_waveform_modes timer_compare_waveform_modes_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .tick_in(tick_in), .ctrl_in(ctrl_in),
    .force_match_strobe_a_in(force_a), .force_match_strobe_b_in(force_b),
    .count_wr_in(count_wr), .count_wr_data_in(count_data),
    .cmp_a_wr_in(cmp_a_wr), .cmp_b_wr_in(cmp_b_wr),
    .cmp_wr_data_in(cmp_data), .match_flag_a_clr_in(clr_a),
    .match_flag_b_clr_in(clr_b), .wrap_flag_clr_in(clr_w),
    .pin_a_in(pin_a), .pin_b_in(pin_b),
    .count_value_out(count_value_out),
    .compare_value_a_out(compare_value_a_out),
    .match_flag_a_out(ma), .match_flag_b_out(mb), .wrap_flag_out(wrap),
    .wave_out_a(wa), .wave_out_b(wb), .pin_a_out(pa), .pin_b_out(pb),
    .pin_a_oe_out(oea), .pin_b_oe_out(oeb)
  );
  pin_load pin_load_i (
    .clk_in(clk_in), .pin_in(pa), .oe_in(oea), .pad_out(pad_a)
  );
  // ==========================================================
  // clock and hang guard
  initial begin
    clk_in = 1'h0;
    forever #2 clk_in = ~clk_in;
  end
  // a run far past the scenario length means a hang
  initial begin
    repeat (50000) @(posedge clk_in);
    n_fail++;
    conclude();
  end
  // ==========================================================
  // drivers: every change lands on a falling edge
  task automatic pulse(ref logic s);
    @(negedge clk_in) s = 1'h1;
    @(negedge clk_in) s = 1'h0;
  endtask : pulse
  // a gap cycle after each tick; the one after the last tick lets the status copy settle
  task automatic step(input int n);
    repeat (n) pulse(tick_in);
    @(negedge clk_in);
  endtask : step
  task automatic wr_cmp(input logic [7:0] a, input logic [7:0] b);
    cmp_data = a;
    pulse(cmp_a_wr);
    cmp_data = b;
    pulse(cmp_b_wr);
  endtask : wr_cmp
  // waves cleared by force, compares written both direct and buffered
  task automatic setup(input row_s r);
    ctrl_in = '{3'h0, 2'h2, 2'h2};
    pulse(force_a);
    pulse(force_b);
    wr_cmp(r.ca, r.cb);
    ctrl_in = '{r.mode, r.sa, r.sb};
    wr_cmp(r.ca, r.cb);
    count_data = r.c0;
    pulse(count_wr);
    pulse(clr_a);
    pulse(clr_b);
    pulse(clr_w);
  endtask : setup
  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(negedge clk_in);
    rst_n_in = 1'h1;
    @(negedge clk_in);
    `CHK("reset", 5'h00, {ma, mb, wrap, wa, wb})
    // first tick after each count write is blocked from matching
    for (int i = 0; i < 10; i++) begin
      setup(rows[i]);
      step(rows[i].n);
      `CHK("count", rows[i].cnt, count_value_out)
      `CHK("flags", rows[i].fl, {ma, mb, wrap, wa, wb})
    end
    step(1);
    `CHK("spike", 2'h2, {ma, wa})
    // buffered compare waits for top in pwm, direct otherwise
    cmp_data = 8'h33;
    pulse(cmp_a_wr);
    @(negedge clk_in);
    `CHK("cmp held", 8'h00, compare_value_a_out)
    count_data = 8'hfe;
    pulse(count_wr);
    step(2);
    `CHK("cmp loaded", 8'h33, compare_value_a_out)
    ctrl_in = '{3'h0, 2'h3, 2'h3};
    cmp_data = 8'h44;
    pulse(cmp_a_wr);
    repeat (2) @(negedge clk_in);
    `CHK("cmp direct", 8'h44, compare_value_a_out)
    // force sets waves only: no flag, counter kept
    count_data = 8'h40;
    pulse(count_wr);
    pulse(clr_a);
    pulse(clr_w);
    pulse(clr_b);
    pulse(force_a);
    pulse(force_b);
    repeat (2) @(negedge clk_in);
    `CHK("force", 5'h03, {ma, mb, wrap, wa, wb})
    `CHK("force count", 8'h40, count_value_out)
    ctrl_in = '{3'h3, 2'h2, 2'h3};
    pulse(force_a);
    repeat (2) @(negedge clk_in);
    `CHK("force pwm", 1'h1, wa)
    // direction set to output before the waveform is expected
    pin_a = '{1'h0, 1'h1};
    pin_b = '{1'h1, 1'h0};
    repeat (3) @(negedge clk_in);
    `CHK("pin a", 3'h7, {pa, oea, pad_a})
    `CHK("pin b oe", 1'h0, oeb)
    ctrl_in = '{3'h3, 2'h0, 2'h3};
    repeat (3) @(negedge clk_in);
    `CHK("pin port", 2'h1, {pa, wa})
    ctrl_in = '{3'h0, 2'h1, 2'h0};
    repeat (3) @(negedge clk_in);
    `CHK("pin mode", 2'h3, {pa, pb})
    // a count write equal to compare must not match
    wr_cmp(8'h10, 8'h10);
    count_data = 8'h10;
    pulse(count_wr);
    step(1);
    `CHK("blocked", 3'h1, {ma, mb, wa})
    count_data = 8'h0f;
    pulse(count_wr);
    step(2);
    `CHK("match", 3'h6, {ma, mb, wa})
    pulse(clr_a);
    @(negedge clk_in);
    `CHK("clear", 1'h0, ma)
    ce_in = 1'h0;
    step(2);
    `CHK("frozen", 8'h11, count_value_out)
    ce_in = 1'h1;
    // a second reset in mid-run clears the wave states
    rst_n_in = 1'h0;
    @(negedge clk_in);
    `CHK("re-reset", 2'h0, {wa, wb})
    // release again: nothing may move without a tick
    rst_n_in = 1'h1;
    repeat (2) @(negedge clk_in);
    `CHK("released", 8'h00, count_value_out)
    `CHK("rel flags", 5'h00, {ma, mb, wrap, wa, wb})
    conclude();
  end
endmodule : timer_compare_waveform_modes_tb

// file: hw/cmp_buffer.sv
// double-buffered compare value store for one channel
// assumes writes and transfer strobes come from the same clock domain
module cmp_buffer #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // software write and transfer control
  input wire logic wr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic buffered_in,
  input wire logic load_in,
  // active value
  output logic [WIDTH-1:0] active_out
);
  logic [WIDTH-1:0] shadow_r;

  // ==========================================================
  // shadow holds the pending value in pwm modes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shadow_r <= WIDTH'(tcmp_pkg::COMPARE_RESET);
    end else if (ce_in && wr_in) begin
      shadow_r <= wr_data_in;
    end
  end

  // direct write when unbuffered; else transfer at top
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_out <= WIDTH'(tcmp_pkg::COMPARE_RESET);
    end else if (ce_in) begin
      if (wr_in && !buffered_in) begin
        active_out <= wr_data_in;
      end else if (load_in && buffered_in) begin
        // a write in the same cycle as the transfer wins over the old one
        active_out <= wr_in ? wr_data_in : shadow_r;
      end
    end
  end
endmodule : cmp_buffer

// file: hw/tcmp_pkg.sv
// package of constants and carrier types for the compare/waveform timer
// assumes a single clock domain and a prescaled timer tick from outside
package tcmp_pkg;
  // ==========================================================
  // waveform mode selector codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_CLEAR_ON_MATCH = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX = 3'h3;
  localparam logic [2:0] MODE_FAST_CMP = 3'h7;
  // ==========================================================
  // output action selector codes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // ==========================================================
  // counter extremes and reset values
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic WAVE_RESET = 1'h0;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam int MODE_HIGH_BIT = 2;

  // software side control fields
  typedef struct packed {
    logic [2:0] wave_mode_sel;
    logic [1:0] output_action_sel_a;
    logic [1:0] output_action_sel_b;
  } timer_ctrl_s;

  // per-pin port settings from the general i/o block
  typedef struct packed {
    logic port_value;
    logic port_dir;
  } port_pin_s;
endpackage : tcmp_pkg

// file: hw/timer_compare_waveform_modes.sv
// 8-bit timer counter with compare match waveform outputs and pin override
// assumes tick_in is a one-cycle prescaled enable from the same clock
//
// Functional notes
// - reset clears both internal waveform output states to zero
// - nonzero action selector puts waveform state on pin, direction kept
// - pin override depends only on the action selector, not on mode
// - action selector zero leaves waveform state unchanged on match
// - new action selector acts at the first match after the write
// - force strobe applies the action at once in non-pwm modes
// - counting depends on mode only; actions only shape outputs
// - normal mode counts up always and wraps 0xff to 0x00
// - normal mode sets wrap flag as counter becomes zero; set only
// - normal mode accepts counter writes at any time
// - clear-on-match mode uses compare a as top and clears there
// - compare a unbuffered there; value below count misses until wrap
// - clear-on-match with selector a one toggles output a per match
// - clear-on-match sets match flag a each time top is reached
// - clear-on-match sets wrap flag when counter wraps max to zero
// - fast pwm counts zero to top; top is 0xff or compare a
// - fast pwm clears to zero on the tick after reaching top
// - fast pwm selector 2 clears on match sets at bottom; 3 inverse
// - fast pwm sets wrap flag each time counter reaches top
// - fast pwm selector 1 toggles a only with mode high bit; not b
// - fast pwm compare zero gives spike, max gives constant level
// - pwm compare writes buffered to top; other modes write directly
// - match sets flag on the next tick; writing one clears it
// - forced match updates output only, no flag, no counter change
// - counter write blocks all matches in the next timer tick
module timer_compare_waveform_modes (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic tick_in,
  // control fields
  input wire tcmp_pkg::timer_ctrl_s ctrl_in,
  input wire logic force_match_strobe_a_in,
  input wire logic force_match_strobe_b_in,
  // counter and compare writes
  input wire logic count_wr_in,
  input wire logic [7:0] count_wr_data_in,
  input wire logic cmp_a_wr_in,
  input wire logic cmp_b_wr_in,
  input wire logic [7:0] cmp_wr_data_in,
  // flag clears (write one)
  input wire logic match_flag_a_clr_in,
  input wire logic match_flag_b_clr_in,
  input wire logic wrap_flag_clr_in,
  // port settings of the two pins
  input wire tcmp_pkg::port_pin_s pin_a_in,
  input wire tcmp_pkg::port_pin_s pin_b_in,
  // status
  output logic [7:0] count_value_out,
  output logic [7:0] compare_value_a_out,
  output logic match_flag_a_out,
  output logic match_flag_b_out,
  output logic wrap_flag_out,
  // pins
  output logic wave_out_a,
  output logic wave_out_b,
  output logic pin_a_out,
  output logic pin_b_out,
  output logic pin_a_oe_out,
  output logic pin_b_oe_out
);
  // ==========================================================
  // mode decode and counter control
  typedef enum logic [2:0] {
    CNT_NORMAL = 3'b001,
    CNT_CLEAR = 3'b010,
    CNT_FAST = 3'b100
  } cnt_kind_e;

  logic [7:0] count_r;
  logic [7:0] cmp_b_r;
  logic [7:0] top_val;
  logic block_r;
  logic match_a;
  logic match_b;
  logic at_top;
  logic fast_pwm;
  logic [1:0] force_r;
  cnt_kind_e kind;

  // pwm check is reused by compare buffers, forcing and waveform logic
  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = (m == tcmp_pkg::MODE_FAST_MAX) || (m == tcmp_pkg::MODE_FAST_CMP);
  endfunction : is_pwm

  // mode to counting behaviour; only the mode selector matters
  always_comb begin
    case (ctrl_in.wave_mode_sel)
      tcmp_pkg::MODE_CLEAR_ON_MATCH: kind = CNT_CLEAR;
      tcmp_pkg::MODE_FAST_MAX, tcmp_pkg::MODE_FAST_CMP: kind = CNT_FAST;
      default: kind = CNT_NORMAL;
    endcase
  end

  assign fast_pwm = is_pwm(ctrl_in.wave_mode_sel);
  // top source: compare a in clear-on-match and mode 7, else max
  assign top_val = (kind == CNT_CLEAR ||
                    ctrl_in.wave_mode_sel == tcmp_pkg::MODE_FAST_CMP) ?
                   compare_value_a_out : tcmp_pkg::COUNT_MAX;
  assign at_top = (count_r == top_val);
  // a counter write blocks matches for the following tick
  assign match_a = (count_r == compare_value_a_out) && !block_r;
  assign match_b = (count_r == cmp_b_r) && !block_r;

  // compare buffers; transfer at top in pwm modes
  cmp_buffer #(.WIDTH(8)) u_cmp_a (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .wr_in(cmp_a_wr_in),
    .wr_data_in(cmp_wr_data_in),
    .buffered_in(fast_pwm),
    .load_in(tick_in && at_top),
    .active_out(compare_value_a_out)
  );

  cmp_buffer #(.WIDTH(8)) u_cmp_b (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .wr_in(cmp_b_wr_in),
    .wr_data_in(cmp_wr_data_in),
    .buffered_in(fast_pwm),
    .load_in(tick_in && at_top),
    .active_out(cmp_b_r)
  );

  // ==========================================================
  // counter; software write has priority over counting
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_r <= tcmp_pkg::COUNT_BOTTOM;
    end else if (ce_in) begin
      if (count_wr_in) begin
        count_r <= count_wr_data_in;
      end else if (tick_in) begin
        case (kind)
          // unbuffered top: a missed match runs on to max and wraps
          CNT_CLEAR: count_r <= at_top ? tcmp_pkg::COUNT_BOTTOM :
                                count_r + 8'h01;
          CNT_FAST: count_r <= at_top ? tcmp_pkg::COUNT_BOTTOM :
                               count_r + 8'h01;
          default: count_r <= count_r + 8'h01;
        endcase
      end
    end
  end

  // block stays armed until the next tick, so a stopped timer keeps it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      block_r <= 1'h0;
    end else if (ce_in) begin
      if (count_wr_in) begin
        block_r <= 1'h1;
      end else if (tick_in) begin
        block_r <= 1'h0;
      end
    end
  end

  // ==========================================================
  // flags: hardware set wins over a same-cycle clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wrap_flag_out <= 1'h0;
    end else if (ce_in) begin
      if (tick_in && !count_wr_in &&
          ((kind == CNT_FAST) ? at_top :
           count_r == tcmp_pkg::COUNT_MAX)) begin
        // normal/clear: set as count wraps max to zero; fast: at top
        wrap_flag_out <= 1'h1;
      end else if (wrap_flag_clr_in) begin
        wrap_flag_out <= 1'h0;
      end
    end
  end

  // match flags set on the tick after the match is seen
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      match_flag_a_out <= 1'h0;
      match_flag_b_out <= 1'h0;
    end else if (ce_in) begin
      if (tick_in && match_a) begin
        match_flag_a_out <= 1'h1;
      end else if (match_flag_a_clr_in) begin
        match_flag_a_out <= 1'h0;
      end
      if (tick_in && match_b) begin
        match_flag_b_out <= 1'h1;
      end else if (match_flag_b_clr_in) begin
        match_flag_b_out <= 1'h0;
      end
    end
  end

  // force strobes are registered so the action lands one cycle later
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      force_r <= 2'h0;
    end else if (ce_in) begin
      force_r <= fast_pwm ? 2'h0 :
                 {force_match_strobe_b_in, force_match_strobe_a_in};
    end
  end

  // ==========================================================
  // waveform output state per channel
  logic [1:0] wave_r;
  logic [1:0] match_v;
  logic [1:0][1:0] act_v;

  assign match_v = {match_b, match_a};
  assign act_v = {ctrl_in.output_action_sel_b, ctrl_in.output_action_sel_a};

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_wave
      logic nxt;
      logic toggle_ok;
      // toggle in fast pwm only for channel a with the mode high bit
      assign toggle_ok = (ch == 0) &&
                         ctrl_in.wave_mode_sel[tcmp_pkg::MODE_HIGH_BIT];
      always_comb begin
        nxt = wave_r[ch];
        if (fast_pwm) begin
          if (tick_in && match_v[ch]) begin
            // compare match edge; selector read at match time only
            case (act_v[ch])
              tcmp_pkg::ACT_TOGGLE: nxt = toggle_ok ? ~wave_r[ch] : wave_r[ch];
              tcmp_pkg::ACT_CLEAR: nxt = 1'h0;
              tcmp_pkg::ACT_SET: nxt = 1'h1;
              default: nxt = wave_r[ch];
            endcase
          end else if (tick_in && at_top) begin // bottom is not a match
            // bottom edge; compare max then re-asserts same level at top
            case (act_v[ch])
              tcmp_pkg::ACT_CLEAR: nxt = 1'h1;
              tcmp_pkg::ACT_SET: nxt = 1'h0;
              default: nxt = wave_r[ch];
            endcase
          end
        end else if ((tick_in && match_v[ch]) || force_r[ch]) begin
          // forced match touches only the output state
          case (act_v[ch])
            tcmp_pkg::ACT_TOGGLE: nxt = ~wave_r[ch];
            tcmp_pkg::ACT_CLEAR: nxt = 1'h0;
            tcmp_pkg::ACT_SET: nxt = 1'h1;
            default: nxt = wave_r[ch];
          endcase
        end
      end

      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          wave_r[ch] <= tcmp_pkg::WAVE_RESET;
        end else if (ce_in) begin
          wave_r[ch] <= nxt;
        end
      end
    end
  endgenerate

  // ==========================================================
  // pin override registered; direction always from the port bit
  logic pin_a_nxt;
  logic pin_b_nxt;

  // override follows selector only, whatever the mode
  assign pin_a_nxt = (|ctrl_in.output_action_sel_a) ? g_wave[0].nxt :
                     pin_a_in.port_value;
  assign pin_b_nxt = (|ctrl_in.output_action_sel_b) ? g_wave[1].nxt :
                     pin_b_in.port_value;

  // wave and pin outputs mirror next state so they align with wave_r; the count copy lags count_r a cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_a_out <= 1'h0;
      pin_b_out <= 1'h0;
      pin_a_oe_out <= 1'h0;
      pin_b_oe_out <= 1'h0;
      wave_out_a <= 1'h0;
      wave_out_b <= 1'h0;
      count_value_out <= tcmp_pkg::COUNT_BOTTOM;
    end else if (ce_in) begin
      pin_a_out <= pin_a_nxt;
      pin_b_out <= pin_b_nxt;
      // without the direction bit the waveform never reaches the pin
      pin_a_oe_out <= pin_a_in.port_dir;
      pin_b_oe_out <= pin_b_in.port_dir;
      wave_out_a <= g_wave[0].nxt;
      wave_out_b <= g_wave[1].nxt;
      count_value_out <= count_r;
    end
  end

  // ==========================================================
  // assertions
  property p_reset_wave;
    @(posedge clk_in) $rose(rst_n_in) |-> (wave_r == 2'h0);
  endproperty
  a_reset_wave: assert property (p_reset_wave)
    else $error("wave state not zero after reset");

  property p_override;
    @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && (ctrl_in.output_action_sel_a != 2'h0) |=>
        pin_a_out == wave_r[0];
  endproperty
  a_override: assert property (p_override)
    else $error("pin a not overridden by wave state");

  property p_zero_holds;
    @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && ctrl_in.output_action_sel_a == 2'h0 |=> $stable(wave_r[0]);
  endproperty
  a_zero_holds: assert property (p_zero_holds)
    else $error("wave a changed with selector zero");

  property p_normal_wrap;
    @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && tick_in && !count_wr_in && kind == CNT_NORMAL &&
      count_r == 8'hff |=> count_r == 8'h00 && wrap_flag_out;
  endproperty
  a_normal_wrap: assert property (p_normal_wrap)
    else $error("normal wrap or flag missing");

  property p_clear_top;
    @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && tick_in && !count_wr_in && kind == CNT_CLEAR && at_top |=>
        count_r == 8'h00;
  endproperty
  a_clear_top: assert property (p_clear_top)
    else $error("clear-on-match did not clear at top");

  property p_flag_a;
    @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && tick_in && match_a |=> match_flag_a_out;
  endproperty
  a_flag_a: assert property (p_flag_a)
    else $error("match flag a not set");

  property p_block;
    @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && count_wr_in |=> !match_a && !match_b;
  endproperty
  a_block: assert property (p_block)
    else $error("match seen right after counter write");

  property p_fast_bottom;
    @(posedge clk_in) disable iff (!rst_n_in)
      ce_in && tick_in && fast_pwm && at_top && !match_a &&
      ctrl_in.output_action_sel_a == 2'h2 |=> wave_r[0];
  endproperty
  a_fast_bottom: assert property (p_fast_bottom)
    else $error("non-inverting output not set at bottom");

  c_wrap: cover property (@(posedge clk_in) wrap_flag_out);
  c_force: cover property (@(posedge clk_in) force_r[0]);
  c_fast_match: cover property (@(posedge clk_in) fast_pwm && match_a);
endmodule : timer_compare_waveform_modes
